// file: include/crfs_pkg.sv
`default_nettype none
package crfs_pkg;
    // Widths and field positions
    localparam int GPR_COUNT  = 8;
    localparam int DATA_W     = 32;
    localparam int HALF_W     = 16;
    localparam int BYTE_W     = 8;
    localparam int EXT_LSB    = 16;
    localparam int HIGH_LSB   = 8;
    localparam int ADDR_W     = 24;
    localparam int ADDR_1MB_W = 20;
    localparam int SP_INDEX   = 7;
    localparam int BITNUM_W   = 3;
    // Half-carry bit positions per operand size
    localparam int HC_BIT_B   = 3;
    localparam int HC_BIT_W   = 11;
    localparam int HC_BIT_L   = 27;
    // Address steps
    localparam logic [ADDR_W-1:0] PC_STEP   = 24'h000002;
    localparam logic [DATA_W-1:0] SP_STEP_W = 32'h00000002;
    localparam logic [DATA_W-1:0] SP_STEP_L = 32'h00000004;
    // Size masks
    localparam logic [DATA_W-1:0] MASK_B = 32'h000000FF;
    localparam logic [DATA_W-1:0] MASK_W = 32'h0000FFFF;
    localparam logic [DATA_W-1:0] MASK_L = 32'hFFFFFFFF;
    // Decimal adjust constants
    localparam logic [7:0] BCD_MAX_BYTE = 8'h99;
    localparam logic [3:0] BCD_MAX_DIG  = 4'h9;
    localparam logic [7:0] BCD_ADJ_HI   = 8'h60;
    localparam logic [7:0] BCD_ADJ_LO   = 8'h06;
    // Reset value of the flags: only the interrupt mask is set, all other flag bits cleared
    localparam logic [7:0] FLAGS_RESET  = 8'h80;

    typedef enum logic [1:0] {SZ_BYTE, SZ_WORD, SZ_LONG} crfs_size_t;

    typedef enum logic [4:0] {
        OP_NONE, OP_MOV, OP_ADD, OP_ADDX, OP_SUB, OP_SUBX, OP_CMP, OP_NEG,
        OP_AND, OP_OR, OP_XOR, OP_SHL, OP_SHR, OP_SAR, OP_ROL, OP_ROR,
        OP_BLD, OP_BAND, OP_BOR, OP_BXOR, OP_BST, OP_BSET, OP_BCLR,
        OP_DAA, OP_DAS, OP_LDF, OP_STF, OP_ANDF, OP_ORF, OP_XORF, OP_EXC
    } crfs_op_t;

    typedef enum logic [2:0] {SP_NONE, SP_PUSH_W, SP_PUSH_L, SP_POP_W, SP_POP_L} crfs_sp_t;

    typedef enum logic [3:0] {
        CC_T, CC_F, CC_HI, CC_LS, CC_CC, CC_CS, CC_NE, CC_EQ,
        CC_VC, CC_VS, CC_PL, CC_MI, CC_GE, CC_LT, CC_GT, CC_LE
    } crfs_cond_t;

    // Flag register, bit 7 down to bit 0
    typedef struct packed {
        logic i;
        logic ui;
        logic h;
        logic u;
        logic n;
        logic z;
        logic v;
        logic c;
    } crfs_flags_t;

    // One datapath operation on a register view
    typedef struct packed {
        logic              valid;
        crfs_op_t          op;
        crfs_size_t        size;
        logic [2:0]        idx;
        logic              hi;
        logic [DATA_W-1:0] opnd;
    } crfs_exec_t;

    // Effective address request
    typedef struct packed {
        logic              valid;
        crfs_size_t        size;
        logic [ADDR_W-1:0] addr;
    } crfs_ea_t;
endpackage : crfs_pkg
`default_nettype wire

// file: logic/crfs_core.sv
// Summary of operation
// - Eight alike 32-bit registers, usable as data or address, 32/16/8-bit access.
// - Each register splits into an extended and a regular 16-bit half.
// - Each regular half splits into a high and a low byte register.
// - Register seven is also the stack pointer for calls and exceptions.
// - Program counter is 24 bits; its bit 0 reads as zero on fetch.
// - Flag bits 7..0 are I, UI, H, U, N, Z, V, C.
// - I set blocks all but the non-maskable interrupt; exceptions set I.
// - Bits 6 and 4 are free through flag transfer and logic operations.
// - Byte add/sub/compare/negate set H from carry or borrow at bit 3.
// - Word add/sub/compare/negate set H from carry or borrow at bit 11.
// - Longword add/sub/compare/negate set H from carry or borrow at bit 27.
// - N copies the result sign bit; Z is one for a zero result, except add/sub with extend only keep or clear Z.
// - V is one on arithmetic overflow, zero after move, logic and shift operations.
// - C holds add carry, subtract borrow, or the bit shifted out.
// - Bit operations use C as a one-bit accumulator, source and destination.
// - Branches test N Z V C; flags loadable, storable, AND/OR/XOR-able.
// - Reset loads the counter from the vector, sets I and clears the other flags; registers undefined.
// - Advanced mode only, effective addresses span 16 Mbytes linearly.
// - In 1-Mbyte modes the upper 4 address bits are ignored; only ea_out_r clears them, fetch_addr_r keeps them.
// - Word, longword and fetch accesses force address bit 0 to zero.
// - Single-bit operations pick bit 0 to 7 of a byte operand.
// - Decimal adjust treats a byte as two packed 4-bit BCD digits.
`default_nettype none
module crfs_core
    import crfs_pkg::*;
(
    input  wire logic              mclk,         // Core clock
    input  wire logic              rst_n,        // Synchronous reset
    input  wire crfs_exec_t        exec,         // Datapath operation
    input  wire crfs_sp_t          sp_op,        // Implicit stack pointer step
    input  wire logic [2:0]        rd_idx,       // Read port register
    input  wire logic              rd_hi,        // Read port half or byte select
    input  wire crfs_size_t        rd_size,      // Read port size
    input  wire logic              vec_valid,    // Reset vector word present
    input  wire logic [ADDR_W-1:0] vec_addr,     // Reset vector value
    input  wire logic              pc_load,      // Jump or branch target load
    input  wire logic [ADDR_W-1:0] pc_target,    // Target address
    input  wire logic              pc_inc,       // Step past a fetched word
    input  wire crfs_ea_t          ea_req,       // Effective address request
    input  wire logic              mode_1mb,     // 1-Mbyte system mode
    input  wire crfs_cond_t        cond,         // Branch condition to test
    input  wire logic              irq_req,      // Maskable interrupt request
    input  wire logic              nmi_req,      // Non-maskable interrupt
    output logic [DATA_W-1:0]      rd_data_r,    // Read port data
    output logic [DATA_W-1:0]      sp_r,         // Stack pointer copy
    output logic [ADDR_W-1:0]      pc_r,         // Program counter
    output logic [ADDR_W-1:0]      fetch_addr_r, // Even fetch address
    output logic [ADDR_W-1:0]      ea_out_r,     // Aligned effective address
    output crfs_flags_t            flags_r,      // Condition flags
    output logic                   cond_true_r,  // Branch condition result
    output logic                   irq_take_r,   // Interrupt accepted
    output logic                   vec_wait_r    // Waiting for reset vector
);

    // Mask for an operand size
    function automatic logic [DATA_W-1:0] crfs_mask(input crfs_size_t sz);
        case (sz)
            SZ_BYTE: crfs_mask = MASK_B;
            SZ_WORD: crfs_mask = MASK_W;
            default: crfs_mask = MASK_L;
        endcase
    endfunction : crfs_mask

    // Sign bit position for an operand size
    function automatic int crfs_msb(input crfs_size_t sz);
        case (sz)
            SZ_BYTE: crfs_msb = BYTE_W - 1;
            SZ_WORD: crfs_msb = HALF_W - 1;
            default: crfs_msb = DATA_W - 1;
        endcase
    endfunction : crfs_msb

    // Bit that receives the half carry
    function automatic int crfs_hpos(input crfs_size_t sz);
        case (sz)
            SZ_BYTE: crfs_hpos = HC_BIT_B + 1;
            SZ_WORD: crfs_hpos = HC_BIT_W + 1;
            default: crfs_hpos = HC_BIT_L + 1;
        endcase
    endfunction : crfs_hpos

    // Extract a 32, 16 or 8-bit view, zero extended
    function automatic logic [DATA_W-1:0] crfs_view(input logic [DATA_W-1:0] r,
                                                    input logic hi, input crfs_size_t sz);
        case (sz)
            SZ_BYTE: crfs_view = hi ? {24'h000000, r[HIGH_LSB +: BYTE_W]}
                                    : {24'h000000, r[0 +: BYTE_W]};
            SZ_WORD: crfs_view = hi ? {16'h0000, r[EXT_LSB +: HALF_W]}
                                    : {16'h0000, r[0 +: HALF_W]};
            default: crfs_view = r;
        endcase
    endfunction : crfs_view

    // Merge a view back into its register, other parts untouched
    function automatic logic [DATA_W-1:0] crfs_merge(input logic [DATA_W-1:0] r,
                                                     input logic [DATA_W-1:0] v,
                                                     input logic hi, input crfs_size_t sz);
        logic [DATA_W-1:0] m;
        m = r;
        case (sz)
            SZ_BYTE: begin
                if (hi) begin
                    m[HIGH_LSB +: BYTE_W] = v[0 +: BYTE_W];
                end else begin
                    m[0 +: BYTE_W] = v[0 +: BYTE_W];
                end
            end
            SZ_WORD: begin
                if (hi) begin
                    m[EXT_LSB +: HALF_W] = v[0 +: HALF_W];
                end else begin
                    m[0 +: HALF_W] = v[0 +: HALF_W];
                end
            end
            default: m = v;
        endcase
        crfs_merge = m;
    endfunction : crfs_merge

    // Branch condition from N Z V C
    function automatic logic crfs_test(input crfs_cond_t cc, input crfs_flags_t f);
        case (cc)
            CC_T:    crfs_test = 1'b1;
            CC_F:    crfs_test = 1'b0;
            CC_HI:   crfs_test = !(f.c | f.z);
            CC_LS:   crfs_test = f.c | f.z;
            CC_CC:   crfs_test = !f.c;
            CC_CS:   crfs_test = f.c;
            CC_NE:   crfs_test = !f.z;
            CC_EQ:   crfs_test = f.z;
            CC_VC:   crfs_test = !f.v;
            CC_VS:   crfs_test = f.v;
            CC_PL:   crfs_test = !f.n;
            CC_MI:   crfs_test = f.n;
            CC_GE:   crfs_test = !(f.n ^ f.v);
            CC_LT:   crfs_test = f.n ^ f.v;
            CC_GT:   crfs_test = !(f.z | (f.n ^ f.v));
            default: crfs_test = f.z | (f.n ^ f.v);
        endcase
    endfunction : crfs_test

    logic [DATA_W-1:0] gpr_r [GPR_COUNT];
    logic [DATA_W-1:0] gpr_nxt [GPR_COUNT];
    logic [DATA_W-1:0] opa;
    logic [DATA_W-1:0] opb;
    logic [DATA_W-1:0] res;
    logic [DATA_W:0]   sum;
    logic [DATA_W:0]   xsum;
    logic [DATA_W-1:0] x;
    logic [DATA_W-1:0] y;
    logic [7:0]        adj;
    logic              wr_en;
    int                m;
    crfs_flags_t       flags_nxt;

    // Datapath: operands, result, flags and register file update
    always_comb begin
        gpr_nxt = gpr_r;
        flags_nxt = flags_r;
        m = crfs_msb(exec.size);
        opa = crfs_view(gpr_r[exec.idx], exec.hi, exec.size);
        opb = exec.opnd & crfs_mask(exec.size);
        x = opa;
        y = opb;
        sum = '0;
        xsum = '0;
        res = opa;
        adj = 8'h00;
        wr_en = 1'b0;
        // Implicit stack pointer steps
        case (sp_op)
            SP_PUSH_W: gpr_nxt[SP_INDEX] = gpr_r[SP_INDEX] - SP_STEP_W;
            SP_PUSH_L: gpr_nxt[SP_INDEX] = gpr_r[SP_INDEX] - SP_STEP_L;
            SP_POP_W:  gpr_nxt[SP_INDEX] = gpr_r[SP_INDEX] + SP_STEP_W;
            SP_POP_L:  gpr_nxt[SP_INDEX] = gpr_r[SP_INDEX] + SP_STEP_L;
            default:   gpr_nxt[SP_INDEX] = gpr_r[SP_INDEX];
        endcase
        if (exec.valid) begin
            case (exec.op)
                OP_MOV, OP_AND, OP_OR, OP_XOR: begin
                    case (exec.op)
                        OP_AND:  res = opa & opb;
                        OP_OR:   res = opa | opb;
                        OP_XOR:  res = opa ^ opb;
                        default: res = opb;
                    endcase
                    wr_en = 1'b1;
                    flags_nxt.n = res[m];
                    flags_nxt.z = (res == '0);
                    flags_nxt.v = 1'b0;
                end
                OP_ADD, OP_ADDX, OP_SUB, OP_SUBX, OP_CMP, OP_NEG: begin
                    if (exec.op == OP_NEG) begin
                        x = '0;
                        y = opa;
                    end
                    if (exec.op == OP_ADD || exec.op == OP_ADDX) begin
                        sum = {1'b0, x} + {1'b0, y} + {32'h0, exec.op == OP_ADDX && flags_r.c};
                    end else begin
                        sum = {1'b0, x} - {1'b0, y} - {32'h0, exec.op == OP_SUBX && flags_r.c};
                    end
                    xsum = {1'b0, x} ^ {1'b0, y} ^ sum;
                    res = sum[DATA_W-1:0] & crfs_mask(exec.size);
                    wr_en = (exec.op != OP_CMP);
                    flags_nxt.h = xsum[crfs_hpos(exec.size)];
                    flags_nxt.c = xsum[m + 1];
                    flags_nxt.n = res[m];
                    // Extend forms only keep or clear Z, for multi-precision chains
                    if (exec.op == OP_ADDX || exec.op == OP_SUBX) begin
                        flags_nxt.z = flags_r.z & (res == '0);
                    end else begin
                        flags_nxt.z = (res == '0);
                    end
                    if (exec.op == OP_ADD || exec.op == OP_ADDX) begin
                        flags_nxt.v = (x[m] == y[m]) && (res[m] != x[m]);
                    end else begin
                        flags_nxt.v = (x[m] != y[m]) && (res[m] != x[m]);
                    end
                end
                OP_SHL, OP_SHR, OP_SAR, OP_ROL, OP_ROR: begin
                    case (exec.op)
                        OP_SHL:  res = opa << 1;
                        OP_SHR:  res = opa >> 1;
                        OP_SAR:  res = (opa >> 1) | ({31'h0, opa[m]} << m);
                        OP_ROL:  res = (opa << 1) | {31'h0, opa[m]};
                        default: res = (opa >> 1) | ({31'h0, opa[0]} << m);
                    endcase
                    res = res & crfs_mask(exec.size);
                    wr_en = 1'b1;
                    flags_nxt.c = (exec.op == OP_SHL || exec.op == OP_ROL) ? opa[m] : opa[0];
                    flags_nxt.n = res[m];
                    flags_nxt.z = (res == '0);
                    flags_nxt.v = 1'b0;
                end
                OP_BLD, OP_BAND, OP_BOR, OP_BXOR, OP_BST, OP_BSET, OP_BCLR: begin
                    // Byte operand, bit number 0 to 7 from the operand field
                    opa = crfs_view(gpr_r[exec.idx], exec.hi, SZ_BYTE);
                    res = opa;
                    case (exec.op)
                        OP_BLD:  flags_nxt.c = opa[exec.opnd[BITNUM_W-1:0]];
                        OP_BAND: flags_nxt.c = flags_r.c & opa[exec.opnd[BITNUM_W-1:0]];
                        OP_BOR:  flags_nxt.c = flags_r.c | opa[exec.opnd[BITNUM_W-1:0]];
                        OP_BXOR: flags_nxt.c = flags_r.c ^ opa[exec.opnd[BITNUM_W-1:0]];
                        OP_BST:  res[exec.opnd[BITNUM_W-1:0]] = flags_r.c;
                        OP_BSET: res[exec.opnd[BITNUM_W-1:0]] = 1'b1;
                        default: res[exec.opnd[BITNUM_W-1:0]] = 1'b0;
                    endcase
                    if (exec.op == OP_BST || exec.op == OP_BSET || exec.op == OP_BCLR) begin
                        gpr_nxt[exec.idx] = crfs_merge(gpr_r[exec.idx], res, exec.hi, SZ_BYTE);
                    end
                end
                OP_DAA, OP_DAS: begin
                    // Two packed BCD digits in the byte view
                    opa = crfs_view(gpr_r[exec.idx], exec.hi, SZ_BYTE);
                    if (exec.op == OP_DAA) begin
                        if (flags_r.c || opa[7:0] > BCD_MAX_BYTE) begin
                            adj = adj | BCD_ADJ_HI;
                            flags_nxt.c = 1'b1;
                        end
                        if (flags_r.h || opa[3:0] > BCD_MAX_DIG) begin
                            adj = adj | BCD_ADJ_LO;
                        end
                        res = {24'h000000, opa[7:0] + adj};
                    end else begin
                        adj = (flags_r.c ? BCD_ADJ_HI : 8'h00) | (flags_r.h ? BCD_ADJ_LO : 8'h00);
                        res = {24'h000000, opa[7:0] - adj};
                    end
                    gpr_nxt[exec.idx] = crfs_merge(gpr_r[exec.idx], res, exec.hi, SZ_BYTE);
                    flags_nxt.n = res[BYTE_W-1];
                    flags_nxt.z = (res[BYTE_W-1:0] == 8'h00);
                end
                OP_LDF:  flags_nxt = crfs_flags_t'(exec.opnd[BYTE_W-1:0]);
                OP_ANDF: flags_nxt = flags_r & crfs_flags_t'(exec.opnd[BYTE_W-1:0]);
                OP_ORF:  flags_nxt = flags_r | crfs_flags_t'(exec.opnd[BYTE_W-1:0]);
                OP_XORF: flags_nxt = flags_r ^ crfs_flags_t'(exec.opnd[BYTE_W-1:0]);
                OP_STF: begin
                    gpr_nxt[exec.idx] = crfs_merge(gpr_r[exec.idx], {24'h000000, flags_r},
                                                   exec.hi, SZ_BYTE);
                end
                OP_EXC: begin
                    flags_nxt.i = 1'b1;
                    gpr_nxt[SP_INDEX] = gpr_r[SP_INDEX] - SP_STEP_L;
                end
                default: ;
            endcase
            if (wr_en) begin
                gpr_nxt[exec.idx] = crfs_merge(gpr_r[exec.idx], res, exec.hi, exec.size);
            end
        end
    end

    logic [ADDR_W-1:0] pc_nxt;
    logic [ADDR_W-1:0] ea_nxt;
    logic              vec_wait_nxt;

    // Program counter, fetch and effective address alignment
    always_comb begin
        pc_nxt = pc_r;
        vec_wait_nxt = vec_wait_r;
        if (vec_wait_r) begin
            if (vec_valid) begin
                pc_nxt = vec_addr;
                vec_wait_nxt = 1'b0;
            end
        end else if (pc_load) begin
            pc_nxt = pc_target;
        end else if (pc_inc) begin
            pc_nxt = pc_r + PC_STEP;
        end
        ea_nxt = ea_out_r;
        if (ea_req.valid) begin
            ea_nxt = ea_req.addr;
            if (ea_req.size != SZ_BYTE) begin
                ea_nxt[0] = 1'b0;
            end
            if (mode_1mb) begin
                ea_nxt[ADDR_W-1:ADDR_1MB_W] = '0;
            end
        end
    end

    // Register file: no reset, contents undefined until written
    always_ff @(posedge mclk) begin
        gpr_r <= gpr_nxt;
    end

    // Control registers and outputs
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            flags_r      <= crfs_flags_t'(FLAGS_RESET);
            pc_r         <= '0;
            fetch_addr_r <= '0;
            ea_out_r     <= '0;
            vec_wait_r   <= 1'b1;
            rd_data_r    <= '0;
            sp_r         <= '0;
            cond_true_r  <= 1'b0;
            irq_take_r   <= 1'b0;
        end else begin
            flags_r      <= flags_nxt;
            pc_r         <= pc_nxt;
            fetch_addr_r <= {pc_nxt[ADDR_W-1:1], 1'b0};
            ea_out_r     <= ea_nxt;
            vec_wait_r   <= vec_wait_nxt;
            rd_data_r    <= crfs_view(gpr_nxt[rd_idx], rd_hi, rd_size);
            sp_r         <= gpr_nxt[SP_INDEX];
            cond_true_r  <= crfs_test(cond, flags_nxt);
            irq_take_r   <= nmi_req | (irq_req & !flags_nxt.i);
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    a_reset_mask_set: assert property ($rose(rst_n) |-> flags_r.i && vec_wait_r)
        else $error("mask bit not set after reset");
    a_exc_mask_set: assert property (exec.valid && exec.op == OP_EXC |=> flags_r.i)
        else $error("exception did not set mask bit");
    a_irq_blocked: assert property (irq_req && !nmi_req && flags_r.i && !exec.valid
                                    |=> !irq_take_r)
        else $error("masked interrupt accepted");
    a_nmi_taken: assert property (nmi_req |=> irq_take_r)
        else $error("non-maskable interrupt not accepted");
    a_fetch_even: assert property (!fetch_addr_r[0] && fetch_addr_r[ADDR_W-1:1] == pc_r[ADDR_W-1:1])
        else $error("fetch address not even");
    a_ea_aligned: assert property (ea_req.valid && ea_req.size != SZ_BYTE |=> !ea_out_r[0])
        else $error("word access address odd");
    a_ea_1mb_mask: assert property (ea_req.valid && mode_1mb
                                    |=> ea_out_r[ADDR_W-1:ADDR_1MB_W] == '0)
        else $error("upper address bits kept in 1-Mbyte mode");
    a_byte_half_carry: assert property (exec.valid && exec.op == OP_ADD && exec.size == SZ_BYTE
        |=> flags_r.h == (({1'b0, $past(opa[3:0])} + {1'b0, $past(opb[3:0])}) > 5'h0F))
        else $error("byte half carry wrong");
    a_mov_zero_flag: assert property (exec.valid && exec.op == OP_MOV && exec.size == SZ_LONG
        |=> flags_r.z == ($past(exec.opnd) == '0) && !flags_r.v)
        else $error("zero or overflow flag wrong after move");
    a_bit_load_carry: assert property (exec.valid && exec.op == OP_BLD
        |=> flags_r.c == $past(opa[exec.opnd[BITNUM_W-1:0]]))
        else $error("bit load did not reach carry");
    a_pc_step: assert property (!vec_wait_r && !pc_load && pc_inc
                                |=> pc_r == $past(pc_r) + PC_STEP)
        else $error("program counter step wrong");

    c_vector_load: cover property (vec_wait_r && vec_valid ##1 !vec_wait_r);
    c_add_carry: cover property (exec.valid && exec.op == OP_ADD ##1 flags_r.c);
    c_exception: cover property (exec.valid && exec.op == OP_EXC);
    c_daa_adjust: cover property (exec.valid && exec.op == OP_DAA && flags_r.h);

endmodule : crfs_core
`default_nettype wire

// file: sim/tb.sv
`default_nettype none
module tb import crfs_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic              mclk, rst_n, vec_valid, pc_load, pc_inc, mode_1mb, irq_req, nmi_req;
    logic              rd_hi, cond_true_r, irq_take_r, vec_wait_r, h;
    logic [2:0]        rd_idx, i;
    logic [4:0]        ef;
    logic [ADDR_W-1:0] vec_addr, pc_target, pc_r, fetch_addr_r, ea_out_r;
    logic [DATA_W-1:0] rd_data_r, sp_r, a, b, m, av;
    crfs_exec_t        exec;
    crfs_sp_t          sp_op;
    crfs_size_t        rd_size, s;
    crfs_ea_t          ea_req;
    crfs_cond_t        cond;
    crfs_flags_t       flags_r;
    int                n_mismatch, n_checks, w;

    crfs_core dut (.mclk(mclk), .rst_n(rst_n), .exec(exec), .sp_op(sp_op), .rd_idx(rd_idx),
        .rd_hi(rd_hi), .rd_size(rd_size), .vec_valid(vec_valid), .vec_addr(vec_addr),
        .pc_load(pc_load), .pc_target(pc_target), .pc_inc(pc_inc), .ea_req(ea_req),
        .mode_1mb(mode_1mb), .cond(cond), .irq_req(irq_req), .nmi_req(nmi_req),
        .rd_data_r(rd_data_r), .sp_r(sp_r), .pc_r(pc_r), .fetch_addr_r(fetch_addr_r),
        .ea_out_r(ea_out_r), .flags_r(flags_r), .cond_true_r(cond_true_r),
        .irq_take_r(irq_take_r), .vec_wait_r(vec_wait_r));

    // Core clock
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // Compare and count
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // One operation, read port on the view it writes
    task automatic op(input crfs_op_t o, input crfs_size_t sz, input logic [2:0] x,
                      input logic hx, input logic [DATA_W-1:0] v);
        exec = '{1'b1, o, sz, x, hx, v};
        rd_idx = x;
        rd_hi = hx;
        rd_size = sz;
        @(negedge mclk);
    endtask : op

    // Expected {h,n,z,v,c} of an add at width wd
    function automatic logic [4:0] addf(input logic [31:0] x, y, input int wd);
        logic [32:0] t, q, mk;
        mk = (33'h1 << wd) - 33'h1;
        t = ({1'b0, x} & mk) + ({1'b0, y} & mk);
        q = ({1'b0, x} & (mk >> 4)) + ({1'b0, y} & (mk >> 4));
        return {q[wd-4], t[wd-1], (t & mk) == 33'h0,
                x[wd-1] == y[wd-1] && t[wd-1] != x[wd-1], t[wd]};
    endfunction : addf

    // Counts, then verdict
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : print_verdict

    // Hang guard
    initial begin
        #100000;
        n_mismatch++;
        print_verdict();
    end

    // Main sequence
    initial begin
        {rst_n, vec_valid, pc_load, pc_inc, mode_1mb, irq_req, nmi_req, rd_hi, rd_idx} = '0;
        {vec_addr, pc_target, exec, ea_req} = '0;
        sp_op = SP_NONE;
        rd_size = SZ_LONG;
        cond = CC_EQ;
        n_mismatch = 0;
        n_checks = 0;
        void'($urandom(26));
        repeat (4) @(negedge mclk);
        rst_n = 1'b1;
        chk({vec_wait_r, flags_r}, 9'h180);
        {vec_valid, vec_addr, pc_load, pc_target} = {1'b1, 24'h123457, 1'b1, 24'h000101};
        @(negedge mclk);
        vec_valid = 1'b0;
        chk({vec_wait_r, pc_r, fetch_addr_r}, {1'b0, 24'h123457, 24'h123456});
        @(negedge mclk);
        {pc_load, pc_inc} = 2'b01;
        @(negedge mclk);
        pc_inc = 1'b0;
        chk({pc_r, fetch_addr_r}, {24'h000103, 24'h000102});
        for (int k = 0; k < 6; k++) begin
            ea_req = '{1'b1, crfs_size_t'(k % 3), (k == 0) ? 24'hFFFFFF : 24'($urandom)};
            mode_1mb = k[0];
            @(negedge mclk);
            chk(ea_out_r, ea_req.addr & {~{4{k[0]}}, 19'h7FFFF, ea_req.size == SZ_BYTE});
        end
        for (int k = 0; k < 40; k++) begin
            {a, b} = (k < 3) ? {MASK_L, 32'h1} : {32'($urandom), 32'($urandom)};
            s = crfs_size_t'(k % 3);
            w = 8 << s;
            h = s != SZ_LONG && $urandom_range(1) == 1;
            i = 3'($urandom_range(7));
            m = MASK_L >> (32 - w);
            av = h ? a >> ((w == 8) ? 8 : 16) : a;
            ef = addf(av, b, w);
            op(OP_MOV, SZ_LONG, i, 1'b0, a);
            op(OP_ADD, s, i, h, b);
            chk(rd_data_r, (av + b) & m);
            chk({flags_r.h, flags_r.n, flags_r.z, flags_r.v, flags_r.c}, ef);
            chk(cond_true_r, ef[2]);
        end
        op(OP_MOV, SZ_LONG, 3'h3, 1'b0, 32'h11223344);
        op(OP_MOV, SZ_BYTE, 3'h3, 1'b1, 32'h000000AB);
        op(OP_MOV, SZ_WORD, 3'h3, 1'b1, 32'h0000CDEF);
        exec.valid = 1'b0;
        rd_size = SZ_LONG;
        rd_hi = 1'b0;
        @(negedge mclk);
        chk(rd_data_r, 32'hCDEFAB44);
        op(OP_MOV, SZ_BYTE, 3'h2, 1'b0, 32'h04);
        for (int n = 0; n < 8; n++) begin
            op(OP_BLD, SZ_BYTE, 3'h2, 1'b0, 32'(n));
            chk(flags_r.c, n == 2);
        end
        // Packed BCD 19 + 28 adjusts to 47, then a right shift drops a one into C
        op(OP_MOV, SZ_BYTE, 3'h1, 1'b0, 32'h19);
        op(OP_ADD, SZ_BYTE, 3'h1, 1'b0, 32'h28);
        op(OP_DAA, SZ_BYTE, 3'h1, 1'b0, 32'h0);
        chk(rd_data_r, 32'h47);
        cond = CC_CS;
        op(OP_SHR, SZ_BYTE, 3'h1, 1'b0, 32'h0);
        chk({rd_data_r, flags_r.c, cond_true_r}, {32'h23, 2'b11});
        irq_req = 1'b1;
        op(OP_ANDF, SZ_BYTE, 3'h0, 1'b0, 32'h0);
        chk(irq_take_r, 1'b1);
        op(OP_ORF, SZ_BYTE, 3'h0, 1'b0, 32'h50);
        chk(flags_r, 8'h50);
        op(OP_MOV, SZ_LONG, 3'h7, 1'b0, 32'h00FF0100);
        op(OP_EXC, SZ_LONG, 3'h0, 1'b0, 32'h0);
        chk({sp_r, flags_r.i, irq_take_r}, {32'h00FF00FC, 2'b10});
        {exec.valid, nmi_req} = 2'b01;
        sp_op = SP_POP_W;
        @(negedge mclk);
        chk({irq_take_r, sp_r}, {1'b1, 32'h00FF00FE});
        print_verdict();
    end
endmodule : tb
`default_nettype wire
